// ===== core/tfs_pkg.sv
// Constants shared by the T1/J1 frame search block and its CRC helper.
// Assumes one received line bit per enabled clock edge.
package tfs_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 193; // F-bit plus 24 channels
  localparam int unsigned CHANNELS = 24; // Channels per frame
  localparam int unsigned CHAN_BITS = 8; // Bits per channel
  localparam logic [4:0] SF_FRAMES = 5'h0c; // Superframe length
  localparam logic [4:0] ESF_FRAMES = 5'h18; // Extended superframe length
  localparam logic [4:0] AGE_MAX = 5'h1f; // Saturated frame age

  // ----------------------------------------------------------------
  // Alignment patterns, first received bit in the MSB
  // ----------------------------------------------------------------
  localparam logic [11:0] SF_PATTERN = 12'h8dc; // 100011011100
  localparam logic [11:0] SF_J1_MASK = 12'hffe; // Last bit free in J1
  localparam logic [5:0] ESF_PATTERN = 6'h0b; // 001011
  localparam logic [7:0] DDS_MASK = 8'h9f; // Skip D and Y positions
  localparam logic [7:0] DDS_VALUE = 8'h1d; // 0DY11101

  // ----------------------------------------------------------------
  // Sync criteria
  // ----------------------------------------------------------------
  localparam logic [2:0] SF_NEED = 3'h2; // Consecutive SF patterns
  localparam logic [2:0] ESF_NEED = 3'h4; // Consecutive ESF patterns
  localparam logic [2:0] CNT_MAX = 3'h7; // Saturated pattern count
  localparam logic [5:0] CRC6_POLY = 6'h03; // x^6 + x + 1

  // ----------------------------------------------------------------
  // Format select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_SF = 2'h0;
  localparam logic [1:0] FMT_ESF = 2'h1;
  localparam logic [1:0] FMT_DM = 2'h2;

  // Search states, one-hot
  typedef enum logic [3:0] {
    ST_CLEAR = 4'b0001,
    ST_SEARCH = 4'b0010,
    ST_CRC = 4'b0100,
    ST_SYNC = 4'b1000
  } tfs_state_e;

endpackage

// ===== core/tfs_crc6.sv
// Serial CRC-6 accumulator used while confirming an ESF candidate.
// Assumes the caller marks the first bit of each block with start_in.
`timescale 1ns/1ps
module tfs_crc6
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic bit_valid_in,
  input wire logic start_in,
  input wire logic bit_in,
  output logic [5:0] crc_out
);

  // ----------------------------------------------------------------
  // One CRC step, MSB first
  // ----------------------------------------------------------------
  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic b);
    logic fb;
    fb = b ^ c[5];
    crc_step = {c[4:0], 1'b0} ^ (fb ? tfs_pkg::CRC6_POLY : 6'h00);
  endfunction

  // Start restarts from zero so a stale block never leaks in
  wire [5:0] seed = start_in ? 6'h00 : crc_out;

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      crc_out <= 6'h00;
    else if (bit_valid_in)
      crc_out <= crc_step(seed, bit_in);
  end

endmodule // tfs_crc6

// ===== core/tfs_frame_search.sv
// T1/J1 receive frame search for SF, ESF and T1 DM formats.
// Assumes the line receiver delivers one bit with a valid strobe on
// ref_clk_in, and that configuration inputs change only rarely.
`timescale 1ns/1ps
module tfs_frame_search
#(
  parameter int unsigned COLS = tfs_pkg::FRAME_BITS
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic rx_bit_in, // Recovered line bit
  input wire logic rx_bit_valid_in, // One strobe per line bit
  input wire logic [1:0] format_select_in, // SF, ESF or DM
  input wire logic j1_mode_in, // High for J1
  input wire logic mimic_check_enable_in,
  input wire logic mux_pattern_check_select_in,
  input wire logic unframed_bypass_in,
  output logic rx_bit_out, // Stream, one cycle late
  output logic rx_bit_valid_out,
  output logic out_of_frame_status_out,
  output logic multiframe_boundary_pulse_out,
  output logic mimic_seen_flag_out
);

  // Column memory is sized for exactly one frame of columns
  initial
  begin
    if (COLS != tfs_pkg::FRAME_BITS)
      $error("COLS must equal the frame length");
  end

  // ----------------------------------------------------------------
  // Column entry layout: history, FIXED_CHANNEL_PATTERN history, age, pattern count
  // ----------------------------------------------------------------
  // One entry serves every frame phase of a column, so link bits
  // that happen to spell the ESF pattern can upset a pending count.
  localparam int unsigned ENTRY_W = 44;
  localparam logic [12:0] WIN_SF = 13'd2316; // 12 frames of bits
  localparam logic [12:0] WIN_ESF = 13'd4632; // 24 frames of bits
  localparam logic [7:0] LAST_COL = 8'(tfs_pkg::FRAME_BITS - 1);

  // Does the framing history of a column hold the selected pattern
  function automatic logic pattern_hit(input logic [1:0] fmt,
                                       input logic j1,
                                       input logic [23:0] h);
    logic [11:0] sf_mask;
    sf_mask = j1 ? tfs_pkg::SF_J1_MASK : 12'hfff;
    if (fmt == tfs_pkg::FMT_ESF)
      pattern_hit = {h[20], h[16], h[12], h[8], h[4], h[0]} ==
                    tfs_pkg::ESF_PATTERN;
    else
      pattern_hit = (h[11:0] & sf_mask) ==
                    (tfs_pkg::SF_PATTERN & sf_mask);
  endfunction

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire is_esf = format_select_in == tfs_pkg::FMT_ESF;
  wire is_dm = format_select_in == tfs_pkg::FMT_DM;
  wire is_sf = format_select_in == tfs_pkg::FMT_SF;
  // DM is refused in J1; code 3 is unused
  wire fmt_ok = is_sf || is_esf || (is_dm && !j1_mode_in);
  wire search_en = fmt_ok && !unframed_bypass_in;
  wire [4:0] mf_len = is_esf ? tfs_pkg::ESF_FRAMES
                             : tfs_pkg::SF_FRAMES;
  wire [12:0] mimic_win = is_esf ? WIN_ESF : WIN_SF;
  wire [5:0] cfg_now = {format_select_in, j1_mode_in,
                        mimic_check_enable_in,
                        mux_pattern_check_select_in,
                        unframed_bypass_in};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tfs_pkg::tfs_state_e state; // Search state
  tfs_pkg::tfs_state_e next_state;
  logic [ENTRY_W-1:0] col_mem [0:COLS-1]; // One entry per bit column
  logic [7:0] col; // Current bit column
  logic [5:0] cfg_q; // Configuration last seen
  logic [7:0] last8; // Last eight line bits
  logic [7:0] lock_col; // Column holding the F-bits
  logic [4:0] frame_idx; // Frame of the last F-bit seen
  logic [7:0] last_hit_col; // Column of the latest pattern
  logic [12:0] last_hit_age; // Bits since that pattern
  logic [1:0] crc_phase; // 0 wait, 1 compute, 2 collect
  logic [5:0] crc_held; // CRC of the computed multiframe
  logic [5:0] crc_rx; // C1..C6 as received
  logic [5:0] crc_acc; // Running CRC
  logic cfg_valid; // cfg_q holds a real value

  // ----------------------------------------------------------------
  // Column entry update
  // ----------------------------------------------------------------
  wire bit_en = rx_bit_valid_in;
  wire [ENTRY_W-1:0] rd = col_mem[col];
  wire [23:0] e_hist = rd[43:20];
  wire [11:0] e_dds = rd[19:8];
  wire [4:0] e_age = rd[7:3];
  wire [2:0] e_cnt = rd[2:0];
  wire [23:0] new_hist = {e_hist[22:0], rx_bit_in};
  // Channel 24 is the eight bits ahead of this F-bit candidate
  wire dds_ok = (last8 & tfs_pkg::DDS_MASK) ==
                (tfs_pkg::DDS_VALUE & tfs_pkg::DDS_MASK);
  wire [11:0] new_dds = {e_dds[10:0], dds_ok};
  wire dds_cond = mux_pattern_check_select_in ? (&new_dds)
                                              : new_dds[11];
  wire [4:0] age_inc = (e_age == tfs_pkg::AGE_MAX) ? e_age
                                                   : e_age + 5'h01;
  wire pat_hit = pattern_hit(format_select_in, j1_mode_in, new_hist);
  wire hit = pat_hit && (!is_dm || dds_cond);
  // Consecutive means exactly one multiframe after the previous hit
  wire consec = age_inc == mf_len;
  wire [2:0] cnt_inc = (e_cnt == tfs_pkg::CNT_MAX) ? e_cnt
                                                   : e_cnt + 3'h1;
  wire [2:0] cnt_new = hit ? (consec ? cnt_inc : 3'h1)
                           : ((age_inc > mf_len) ? 3'h0 : e_cnt);
  wire [4:0] age_new = hit ? 5'h00 : age_inc;
  wire [ENTRY_W-1:0] wr_data = {new_hist, new_dds, age_new, cnt_new};

  // ----------------------------------------------------------------
  // Mimic detection: the pattern at a second column within one
  // multiframe of another. Only the latest hit is tracked, so a
  // mimic is seen when the hit column changes, a cheap compromise.
  // ----------------------------------------------------------------
  wire hunting = (state == tfs_pkg::ST_SEARCH) ||
                 (state == tfs_pkg::ST_CRC);
  wire mimic_now = bit_en && hunting && search_en && !is_dm &&
                   pat_hit && (col != last_hit_col) &&
                   (last_hit_age < mimic_win);
  wire mimic_block = mimic_check_enable_in && mimic_now;

  // ----------------------------------------------------------------
  // Lock decision per format
  // ----------------------------------------------------------------
  wire [2:0] need = is_esf ? tfs_pkg::ESF_NEED : tfs_pkg::SF_NEED;
  wire lock_sf = is_sf && (cnt_new >= need) && !mimic_block;
  wire lock_esf = is_esf && mimic_check_enable_in &&
                  (cnt_new >= need) && !mimic_block;
  wire lock_dm = is_dm && (cnt_new != 3'h0);
  wire to_crc = is_esf && !mimic_check_enable_in;
  wire search_hit = bit_en && search_en &&
                    (state == tfs_pkg::ST_SEARCH) && hit;
  wire go_sync = search_hit && (lock_sf || lock_esf || lock_dm);
  wire go_crc = search_hit && to_crc;

  // ----------------------------------------------------------------
  // Frame tracking once a candidate column is chosen
  // ----------------------------------------------------------------
  wire at_fbit = bit_en && (col == lock_col);
  wire mf_start = frame_idx == (mf_len - 5'h01); // Next F-bit is frame 1
  wire [4:0] idx_adv = mf_start ? 5'h00 : frame_idx + 5'h01;
  // CRC bits sit in frames 2, 6, ... 22: index 1 modulo 4
  wire crc_slot = at_fbit && (idx_adv[1:0] == 2'h1);
  wire crc_done = (state == tfs_pkg::ST_CRC) && at_fbit && mf_start &&
                  (crc_phase == 2'h2);
  wire crc_match = crc_rx == crc_held;
  wire crc_start = at_fbit && mf_start;
  // F-bits count as ones inside the CRC block
  wire crc_bit = at_fbit ? 1'b1 : rx_bit_in;
  wire restart = cfg_valid && (cfg_now != cfg_q);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      tfs_pkg::ST_CLEAR:
      begin
        // Leave once every column entry is zero
        if (col == LAST_COL)
          next_state = tfs_pkg::ST_SEARCH;
      end
      tfs_pkg::ST_SEARCH:
      begin
        if (go_sync)
          next_state = tfs_pkg::ST_SYNC;
        else if (go_crc)
          next_state = tfs_pkg::ST_CRC;
      end
      tfs_pkg::ST_CRC:
      begin
        // A wrong CRC sends the hunt back to the column scan
        if (crc_done)
          next_state = crc_match ? tfs_pkg::ST_SYNC
                                 : tfs_pkg::ST_SEARCH;
      end
      tfs_pkg::ST_SYNC:
      begin
        next_state = tfs_pkg::ST_SYNC;
      end
      default:
      begin
        next_state = tfs_pkg::ST_CLEAR;
      end
    endcase
    if (restart || !search_en)
      next_state = tfs_pkg::ST_CLEAR;
  end

  // ----------------------------------------------------------------
  // State register and configuration watch
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= tfs_pkg::ST_CLEAR;
      cfg_q <= 6'h00;
      cfg_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cfg_q <= cfg_now;
      cfg_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Column pointer; the clear sweep steps every cycle
  // ----------------------------------------------------------------
  wire clearing = state == tfs_pkg::ST_CLEAR;
  wire col_step = clearing || bit_en;
  wire [7:0] col_next = (col == LAST_COL) ? 8'h00 : col + 8'h01;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      col <= 8'h00;
    else if (restart)
      col <= 8'h00;
    else if (col_step)
      col <= col_next;
  end

  // ----------------------------------------------------------------
  // Column memory, no reset: the clear sweep zeroes it
  // ----------------------------------------------------------------
  wire mem_we = clearing || (bit_en && hunting && search_en);

  always_ff @(posedge ref_clk_in)
  begin
    if (mem_we)
      col_mem[col] <= clearing ? '0 : wr_data;
  end

  // ----------------------------------------------------------------
  // Last eight bits and the most recent pattern column
  // ----------------------------------------------------------------
  wire [12:0] age_step = (last_hit_age == 13'h1fff) ? last_hit_age
                                                    : last_hit_age + 13'h1;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || clearing)
    begin
      last8 <= 8'h00;
      last_hit_col <= 8'h00;
      last_hit_age <= 13'h1fff;
    end
    else if (bit_en)
    begin
      last8 <= {last8[6:0], rx_bit_in};
      last_hit_col <= (hunting && pat_hit) ? col : last_hit_col;
      last_hit_age <= (hunting && pat_hit) ? 13'h0 : age_step;
    end
  end

  // ----------------------------------------------------------------
  // Locked column and frame index
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || clearing)
    begin
      lock_col <= 8'h00;
      frame_idx <= 5'h00;
    end
    else if (go_sync || go_crc)
    begin
      // The matching F-bit closes a multiframe
      lock_col <= col;
      frame_idx <= mf_len - 5'h01;
    end
    else if (at_fbit && !(state == tfs_pkg::ST_SEARCH))
      frame_idx <= idx_adv;
  end

  // ----------------------------------------------------------------
  // CRC-6 confirmation over two multiframes
  // ----------------------------------------------------------------
  tfs_crc6 u_crc6
  (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .bit_valid_in(bit_en),
    .start_in(crc_start),
    .bit_in(crc_bit),
    .crc_out(crc_acc)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || state != tfs_pkg::ST_CRC)
    begin
      crc_phase <= 2'h0;
      crc_held <= 6'h00;
      crc_rx <= 6'h00;
    end
    else if (crc_start && crc_phase == 2'h0)
      crc_phase <= 2'h1; // First block begins
    else if (crc_start && crc_phase == 2'h1)
    begin
      crc_phase <= 2'h2; // Hold CRC of block A
      crc_held <= crc_acc;
    end
    else if (crc_slot && crc_phase == 2'h2)
      crc_rx <= {crc_rx[4:0], rx_bit_in}; // C1 first
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire sync_next = next_state == tfs_pkg::ST_SYNC;
  wire mf_pulse = sync_next && at_fbit && mf_start;
  // Set wins over the restart clear
  wire mimic_next = mimic_now || (mimic_seen_flag_out && !restart);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_bit_out <= 1'b0;
      rx_bit_valid_out <= 1'b0;
      out_of_frame_status_out <= 1'b1;
      multiframe_boundary_pulse_out <= 1'b0;
      mimic_seen_flag_out <= 1'b0;
    end
    else
    begin
      rx_bit_out <= rx_bit_in;
      rx_bit_valid_out <= rx_bit_valid_in;
      out_of_frame_status_out <= !sync_next;
      multiframe_boundary_pulse_out <= mf_pulse;
      mimic_seen_flag_out <= mimic_next;
    end
  end

endmodule // tfs_frame_search

// ===== testbench/tfs_frame_search_asserts.sv
// Checker for the T1/J1 frame search block, bound to its top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module tfs_frame_search_asserts
#(
  parameter int unsigned COLS = 193
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic rx_bit_in,
  input wire logic rx_bit_valid_in,
  input wire logic [1:0] format_select_in,
  input wire logic j1_mode_in,
  input wire logic mimic_check_enable_in,
  input wire logic mux_pattern_check_select_in,
  input wire logic unframed_bypass_in,
  input wire logic rx_bit_out,
  input wire logic rx_bit_valid_out,
  input wire logic out_of_frame_status_out,
  input wire logic multiframe_boundary_pulse_out,
  input wire logic mimic_seen_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  wire logic [5:0] cfg = {format_select_in, j1_mode_in,
    mimic_check_enable_in, mux_pattern_check_select_in,
    unframed_bypass_in}; // Any change restarts the hunt
  wire logic esf = (format_select_in == tfs_pkg::FMT_ESF);
  wire logic [15:0] mf_len = 16'(COLS * (esf ? 24 : 12)); // Bits
  wire logic dm_j1 = (format_select_in == tfs_pkg::FMT_DM) && j1_mode_in;
  logic [15:0] gap; // Valid bits since the last boundary pulse
  logic seen; // A pulse has been seen since reset
  // Gap counter, only meaningful between two pulses
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      gap <= 16'h0000;
      seen <= 1'b0;
    end
    else if (multiframe_boundary_pulse_out)
    begin
      gap <= 16'h0000;
      seen <= 1'b1;
    end
    else if (rx_bit_valid_out)
      gap <= gap + 16'h0001;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_reset_idle;
    $rose(rst_n_in) |-> out_of_frame_status_out && !rx_bit_valid_out &&
      !multiframe_boundary_pulse_out && !mimic_seen_flag_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_bit_copy;
    rx_bit_valid_in |=> rx_bit_valid_out && rx_bit_out == $past(rx_bit_in);
  endproperty
  a_bit_copy: assert property (p_bit_copy)
    else $error("stream copy wrong");
  property p_pulse_in_frame;
    multiframe_boundary_pulse_out |-> rx_bit_valid_out &&
      !out_of_frame_status_out;
  endproperty
  a_pulse_in_frame: assert property (p_pulse_in_frame)
    else $error("pulse outside frame");
  property p_pulse_spacing;
    multiframe_boundary_pulse_out && seen |-> gap == mf_len - 16'h0001;
  endproperty
  a_pulse_spacing: assert property (p_pulse_spacing)
    else $error("pulse spacing wrong");
  property p_oof_holds;
    !out_of_frame_status_out && $stable(cfg) |=> !out_of_frame_status_out;
  endproperty
  a_oof_holds: assert property (p_oof_holds)
    else $error("lock lost without cause");
  property p_bypass;
    unframed_bypass_in ##1 unframed_bypass_in |->
      out_of_frame_status_out && !multiframe_boundary_pulse_out;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("search active while bypassed");
  property p_dm_j1;
    dm_j1 ##1 dm_j1 |-> out_of_frame_status_out;
  endproperty
  a_dm_j1: assert property (p_dm_j1)
    else $error("mux format locked in J1");
  property p_cfg_restart;
    !$stable(cfg) |-> ##[1:4] out_of_frame_status_out;
  endproperty
  a_cfg_restart: assert property (p_cfg_restart)
    else $error("no restart on config change");
  property p_mimic_holds;
    mimic_seen_flag_out && $stable(cfg) |=> mimic_seen_flag_out;
  endproperty
  a_mimic_holds: assert property (p_mimic_holds)
    else $error("mimic flag dropped");
endmodule // tfs_frame_search_asserts

// ===== testbench/tfs_line_rx_model.sv
// Line receiver model: framed SF, ESF or DM streams, one bit a cycle.
// Assumes the bench pops q to predict the block's copied stream.
`timescale 1ns/1ps
module tfs_line_rx_model
(
  input wire logic clk_in,
  output logic bit_out,
  output logic valid_out
);
  logic busy = 1'b0; // High while a stream is sent
  logic [31:0] rnd = 32'h679d8739; // Random source state
  int q[$]; // Bits handed over, oldest first
  initial
  begin
    bit_out = 1'b0;
    valid_out = 1'b0;
  end
  // Released line toggles so a stale level never looks like data
  always @(posedge clk_in)
  begin
    if (!busy)
      bit_out <= ~bit_out;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // opt: 1 twelfth F-bit 1, 2 mimic at column 100, 4 bad fixed bit
  // in frame 5, 8 CRC of multiframe 2 sent in multiframe 3
  // Payload stays zero apart from DM channel 24 and the opt 2 column 100, so no other data column can start a false hunt
  task automatic send(input int fmt, input int nfr, input int opt);
    int f;
    int c;
    int fr;
    logic b;
    logic [5:0] crc;
    crc = 6'h00;
    busy = 1'b1;
    for (f = 0; f < nfr; f++)
    begin
      for (c = 0; c < 193; c++)
      begin
        rnd = lfsr(rnd);
        b = 1'b0;
        fr = (fmt == 1) ? f % 24 + 1 : f % 12 + 1;
        if (c == 0 && fmt == 1)
          b = (fr % 4 == 0) ? tfs_pkg::ESF_PATTERN[6 - fr / 4] :
            (fr % 2 == 1) ? 1'b1 :
            (f / 24 == 2) ? crc[5 - fr / 4] : 1'b0;
        else if (c == 0)
          b = (fr == 12 && opt[0]) ? 1'b1 : tfs_pkg::SF_PATTERN[12 - fr];
        else if (c == 100 && opt[1])
          b = tfs_pkg::SF_PATTERN[12 - fr];
        else if (c > 184 && fmt == 2)
          b = (tfs_pkg::DDS_MASK[192 - c] ? tfs_pkg::DDS_VALUE[192 - c] :
            rnd[2]) ^ (c == 185 && opt[2] && fr == 5);
        // F-bits count as ones in the check sum
        if (opt[3] && f / 24 == 1)
          crc = {crc[4:0], 1'b0} ^
            ((crc[5] ^ (c == 0 || b)) ? 6'h03 : 6'h00);
        @(posedge clk_in);
        bit_out <= b;
        valid_out <= 1'b1;
        q.push_back(b);
      end
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // tfs_line_rx_model

// ===== testbench/test_tfs_frame_search.sv
// Top of the bench for the T1/J1 frame search block.
// Assumes the package, design and model files are compiled first.
`timescale 1ns/1ps
module test_tfs_frame_search;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic j1 = 1'b0;
  logic mim = 1'b0;
  logic sel = 1'b0;
  logic unf = 1'b0;
  wire logic rx_bit;
  wire logic rx_valid;
  logic bit_q, val_q, oof, pulse, mimic;
  int errors = 0;
  int checked = 0;
  int idx = 0; // Next bit index leaving the block
  int lock_at = -1; // Bit index completing the lock, -1 for none
  int mf_len = 2316;
  wire logic locked = lock_at >= 0 && idx >= lock_at;
  always #2 ref_clk_in = ~ref_clk_in;
  tfs_frame_search u_dut
  (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .rx_bit_in(rx_bit), .rx_bit_valid_in(rx_valid),
    .format_select_in(fmt), .j1_mode_in(j1),
    .mimic_check_enable_in(mim), .mux_pattern_check_select_in(sel),
    .unframed_bypass_in(unf), .rx_bit_out(bit_q),
    .rx_bit_valid_out(val_q), .out_of_frame_status_out(oof),
    .multiframe_boundary_pulse_out(pulse), .mimic_seen_flag_out(mimic)
  );
  tfs_line_rx_model u_rx
  (
    .clk_in(ref_clk_in), .bit_out(rx_bit), .valid_out(rx_valid)
  );
  task automatic check(input string name, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", name, e, g);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Every copied bit is compared with the model's prediction
  always @(negedge ref_clk_in)
  begin
    if (rst_n_in && val_q)
    begin
      check("rx_bit_out", u_rx.q.pop_front() != 0, bit_q);
      check("out_of_frame", !locked, oof);
      check("boundary", locked && idx % mf_len == 0, pulse);
      idx++;
    end
  end
  // cfg is {format, j1, mimic check, mux check, unframed}
  task automatic run(input logic [5:0] cfg, input int opt,
    input int nfr, input int lk, input int em);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    {fmt, j1, mim, sel, unf} <= cfg;
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    idx = 0;
    lock_at = (lk < 0) ? -1 : lk * 193;
    mf_len = (cfg[5:4] == 2'h1) ? 4632 : 2316;
    // Clear sweep runs before bits are taken
    repeat (194) @(posedge ref_clk_in);
    u_rx.send(int'(cfg[5:4]), nfr, opt);
    repeat (2) @(posedge ref_clk_in);
    #1;
    if (em < 2)
      check("mimic", em[0], mimic);
  endtask
  initial
  begin
    run(6'h04, 0, 37, 23, 0);
    @(posedge ref_clk_in);
    mim <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1 check("restart", 1'b1, oof);
    run(6'h0c, 1, 25, 23, 0);
    run(6'h04, 1, 25, -1, 0);
    run(6'h00, 2, 25, 23, 1);
    run(6'h04, 2, 25, -1, 1);
    run(6'h05, 0, 25, -1, 0);
    run(6'h14, 0, 97, 95, 0);
    run(6'h10, 8, 73, 72, 2);
    run(6'h20, 4, 25, 23, 0);
    run(6'h22, 4, 25, -1, 0);
    run(6'h22, 0, 25, 23, 0);
    run(6'h28, 0, 25, -1, 0);
    run(6'h30, 0, 2, -1, 0);
    give_verdict();
  end
  // Watchdog a little beyond the planned run length
  initial
  begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule // test_tfs_frame_search
bind tfs_frame_search tfs_frame_search_asserts #(.COLS(COLS)) u_chk
(
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .rx_bit_in(rx_bit_in),
  .rx_bit_valid_in(rx_bit_valid_in), .format_select_in(format_select_in),
  .j1_mode_in(j1_mode_in), .mimic_check_enable_in(mimic_check_enable_in),
  .mux_pattern_check_select_in(mux_pattern_check_select_in),
  .unframed_bypass_in(unframed_bypass_in), .rx_bit_out(rx_bit_out),
  .rx_bit_valid_out(rx_bit_valid_out),
  .out_of_frame_status_out(out_of_frame_status_out),
  .multiframe_boundary_pulse_out(multiframe_boundary_pulse_out),
  .mimic_seen_flag_out(mimic_seen_flag_out)
);
